// ===== core/crt_core.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "crt_defs.svh"

module crt_core
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        count_tick_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic [5:0]  irq_lines,
   output var  logic        irq
);
   import crt_pkg::*;

   logic [2:0]      tick_sync_reg;
   logic            tick_level_reg;
   logic            tick;
   logic [5:0]      sec_reg;
   logic [5:0]      min_reg;
   logic [4:0]      hr_reg;
   logic [2:0]      wk_reg;
   logic            run_req_reg;
   logic            running_reg;
   crt_mode_t       mode_reg;
   logic            h12_reg;
   logic            pm_reg;
   logic [5:0]      c2_reg;
   logic [3:0]      csr_reg;
   logic [5:0]      stat_reg;
   logic [5:0]      mask_reg;
   logic [5:0]      events;
   logic [5:0]      lines_next;
   crt_run_state_t  run_state_reg;
   logic            wr;
   logic            rd;
   logic            hit;
   logic [31:0]     rdata_next;

   // Count source from a pin: three stages, edge once stages two and three agree
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_sync_reg  <= 3'h0;
         tick_level_reg <= 1'b0;
      end
      else
      begin
         tick_sync_reg <= {tick_sync_reg[1:0], count_tick_in};
         if (tick_sync_reg[1] == tick_sync_reg[2])
            tick_level_reg <= tick_sync_reg[2];
      end
   end

   assign tick = (tick_sync_reg[1] == tick_sync_reg[2]) && tick_sync_reg[2] && !tick_level_reg;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;

   // Start/stop handshake measured in count-source ticks
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_state_reg <= CRT_IDLE;
         running_reg   <= 1'b0;
      end
      else
      begin
         unique case (run_state_reg)
            CRT_IDLE:
            begin
               if (run_req_reg)
                  run_state_reg <= CRT_STARTING;
            end
            CRT_STARTING:
            begin
               if (!run_req_reg)
                  run_state_reg <= CRT_IDLE;
               else if (tick)
               begin
                  running_reg   <= 1'b1;
                  run_state_reg <= CRT_RUNNING;
               end
            end
            CRT_RUNNING:
            begin
               if (!run_req_reg)
                  run_state_reg <= CRT_STOPPING;
            end
            CRT_STOPPING:
            begin
               if (tick)
               begin
                  running_reg   <= 1'b0;
                  run_state_reg <= CRT_IDLE;
               end
            end
         endcase
      end
   end

   // Software registers; time and setup writes accepted only while fully stopped
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_req_reg <= 1'b0;
         mode_reg    <= CRT_MODE_RTC;
         h12_reg     <= 1'b0;
         c2_reg      <= `CRT_RST_C2;
         csr_reg     <= `CRT_RST_CSR;
         mask_reg    <= 6'h00;
      end
      else if (wr)
      begin
         if (paddr == `CRT_OFF_CTL1)
         begin
            run_req_reg <= pwdata[`CRT_C1_RUN];
            if (!run_req_reg && !running_reg)
            begin
               mode_reg <= pwdata[`CRT_C1_MODE] ? CRT_MODE_COMPARE : CRT_MODE_RTC;
               h12_reg  <= pwdata[`CRT_C1_H12];
            end
         end
         if (paddr == `CRT_OFF_CTL2 && !run_req_reg && !running_reg)
            c2_reg <= pwdata[5:0];
         if (paddr == `CRT_OFF_CSR && !run_req_reg && !running_reg)
            csr_reg <= pwdata[3:0];
         if (paddr == `CRT_OFF_IRQ_MASK)
            mask_reg <= pwdata[5:0];
      end
   end

   // Time counters; in compare mode the seconds register is the free counter
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sec_reg <= 6'h00;
         min_reg <= 6'h00;
         hr_reg  <= 5'h00;
         wk_reg  <= 3'h0;
         pm_reg  <= 1'b0;
         events  <= 6'h00;
      end
      else
      begin
         events <= 6'h00;
         if (wr && !run_req_reg && !running_reg)
         begin
            if (paddr == `CRT_OFF_SEC)
               sec_reg <= pwdata[5:0];
            if (paddr == `CRT_OFF_MIN)
               min_reg <= pwdata[5:0];
            if (paddr == `CRT_OFF_HR)
               hr_reg <= pwdata[4:0];
            if (paddr == `CRT_OFF_WK)
               wk_reg <= pwdata[2:0];
            if (paddr == `CRT_OFF_CTL1)
               pm_reg <= pwdata[`CRT_C1_PM];
         end
         else if (tick && running_reg && run_req_reg)
         begin
            if (mode_reg == CRT_MODE_COMPARE)
            begin
               sec_reg <= sec_reg + 6'h01;
               if (sec_reg + 6'h01 == min_reg)
                  events[`CRT_IB_COMPARE] <= 1'b1;
            end
            else if (sec_reg != `CRT_SEC_MAX)
            begin
               sec_reg <= sec_reg + 6'h01;
               events[`CRT_IB_SECOND] <= 1'b1;
            end
            else
            begin
               sec_reg <= 6'h00;
               if (min_reg != `CRT_MIN_MAX)
               begin
                  min_reg <= min_reg + 6'h01;
                  events[`CRT_IB_MINUTE] <= 1'b1;
               end
               else
               begin
                  min_reg <= 6'h00;
                  if (hr_reg != `CRT_HR_MAX)
                  begin
                     hr_reg <= hr_reg + 5'h01;
                     pm_reg <= (hr_reg + 5'h01) >= 5'h0c;
                     events[`CRT_IB_HOUR] <= 1'b1;
                  end
                  else
                  begin
                     hr_reg <= 5'h00;
                     pm_reg <= 1'b0;
                     events[`CRT_IB_DAY] <= 1'b1;
                     if (wk_reg != `CRT_WK_MAX)
                        wk_reg <= wk_reg + 3'h1;
                     else
                     begin
                        wk_reg <= 3'h0;
                        events[`CRT_IB_WEEK] <= 1'b1;
                     end
                  end
               end
            end
         end
      end
   end

   // Sticky status: a new event wins over a write-one clear in the same cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         stat_reg <= 6'h00;
      else
      begin
         if (wr && paddr == `CRT_OFF_IRQ_STAT)
            stat_reg <= (stat_reg & ~pwdata[5:0]) | (events & c2_reg);
         else
            stat_reg <= stat_reg | (events & c2_reg);
      end
   end

   // Each line is live only while its enable in control two is set
   assign lines_next = stat_reg & c2_reg & mask_reg;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_lines <= 6'h00;
         irq       <= 1'b0;
      end
      else
      begin
         irq_lines <= lines_next;
         irq       <= |lines_next;
      end
   end

   assign hit = (paddr == `CRT_OFF_SEC) || (paddr == `CRT_OFF_MIN) ||
                (paddr == `CRT_OFF_HR) || (paddr == `CRT_OFF_WK) ||
                (paddr == `CRT_OFF_CTL1) || (paddr == `CRT_OFF_CTL2) ||
                (paddr == `CRT_OFF_CSR) || (paddr == `CRT_OFF_IRQ_STAT) ||
                (paddr == `CRT_OFF_IRQ_MASK);

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      unique case (paddr)
         `CRT_OFF_SEC:      rdata_next[5:0] = sec_reg;
         `CRT_OFF_MIN:      rdata_next[5:0] = min_reg;
         `CRT_OFF_HR:       rdata_next[4:0] = hr_reg;
         `CRT_OFF_WK:       rdata_next[2:0] = wk_reg;
         `CRT_OFF_CTL1:     rdata_next[4:0] = {pm_reg, h12_reg, mode_reg == CRT_MODE_COMPARE,
                                               running_reg, run_req_reg};
         `CRT_OFF_CTL2:     rdata_next[5:0] = c2_reg;
         `CRT_OFF_CSR:      rdata_next[3:0] = csr_reg;
         `CRT_OFF_IRQ_STAT: rdata_next[5:0] = stat_reg;
         `CRT_OFF_IRQ_MASK: rdata_next[5:0] = mask_reg;
         default:           rdata_next = 32'h0000_0000;
      endcase
   end

   // No wait state: setup cycle registers the answer, first access cycle completes
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (rd && !penable)
            prdata <= rdata_next;
      end
   end

endmodule : crt_core

`default_nettype wire

// ===== core/crt_defs.svh
// Operation
// - Compare match raises compare request when enabled
// - Weekday wrapping to zero raises week request
// - Weekday increment raises day request
// - Hour increment raises hour request
// - Minute increment raises minute request
// - Second increment in RTC mode raises second request
// - Six sources on six separate request lines
// - Run request sets running flag within two ticks
// - Clearing run request stops, clears running flag
`ifndef CRT_DEFS_SVH
`define CRT_DEFS_SVH

`define CRT_OFF_SEC      12'h000
`define CRT_OFF_MIN      12'h004
`define CRT_OFF_HR       12'h008
`define CRT_OFF_WK       12'h00c
`define CRT_OFF_CTL1     12'h010
`define CRT_OFF_CTL2     12'h014
`define CRT_OFF_CSR      12'h018
`define CRT_OFF_IRQ_STAT 12'h01c
`define CRT_OFF_IRQ_MASK 12'h020

// Control one fields
`define CRT_C1_RUN       0
`define CRT_C1_RUNNING   1
`define CRT_C1_MODE      2
`define CRT_C1_H12       3
`define CRT_C1_PM        4
// Control two / status / mask bit positions
`define CRT_IB_COMPARE   0
`define CRT_IB_WEEK      1
`define CRT_IB_DAY       2
`define CRT_IB_HOUR      3
`define CRT_IB_MINUTE    4
`define CRT_IB_SECOND    5

`define CRT_RST_C2       6'h00
`define CRT_RST_CSR      4'h0
`define CRT_SEC_MAX      6'h3b
`define CRT_MIN_MAX      6'h3b
`define CRT_HR_MAX       5'h17
`define CRT_WK_MAX       3'h6

`endif

// ===== core/crt_pkg.sv
package crt_pkg;
   typedef enum logic {
      CRT_MODE_RTC,
      CRT_MODE_COMPARE
   } crt_mode_t;
   typedef enum logic [1:0] {
      CRT_IDLE,
      CRT_STARTING,
      CRT_RUNNING,
      CRT_STOPPING
   } crt_run_state_t;
endpackage : crt_pkg

// ===== verification/calendar_timer_irq_and_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module calendar_timer_irq_and_control_bench;
   logic        clk, rst_b, tick, psel, penable, pwrite, e;
   logic        pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [5:0]  irq_lines;
   int          failures, n_checks;
   logic [11:0] ra [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014, 12'h018, 12'h020,
                           12'h01c, 12'h024};
   logic [31:0] rw [9] = '{32'h3a, 32'h3b, 32'h17, 32'h6, 32'h3e, 32'hf, 32'h3f, 32'h3f, 32'h5a};
   logic [31:0] re [9] = '{32'h3a, 32'h3b, 32'h17, 32'h6, 32'h3e, 32'hf, 32'h3f, 32'h0, 32'h0};
   crt_core u_crt_core (.clk(clk), .rst_b(rst_b), .count_tick_in(tick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines), .irq(irq));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic wrap_up;
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   // Release comes only after the edge where ready was seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         failures++;
         wrap_up;
      end
   endtask : apb
   // Long pulse so the three-flop synchroniser sees every tick
   task automatic tk;
      @(posedge clk);
      tick <= 1'b1;
      repeat (8) @(posedge clk);
      tick <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : tk
   task automatic wt(input logic [5:0] m);
      int n;
      n = 0;
      while ((irq_lines & m) === 6'h00 && n < 6)
      begin
         tk;
         n++;
      end
      repeat (3) @(negedge clk);
   endtask : wt
   task automatic run(input logic [31:0] v);
      int n;
      apb(1'b1, 12'h010, v);
      n = 0;
      do
      begin
         tk;
         n++;
         apb(1'b0, 12'h010, 32'h0);
      end
      while (r[1] !== v[0] && n < 4);
      chk("ticks to flag", 32'(n <= 2), 32'h1);
   endtask : run
   initial
   begin
      tick = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("reset lines", {25'h0, irq, irq_lines}, 32'h0);
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b1, ra[i], rw[i]);
         apb(1'b0, ra[i], 32'h0);
         chk("register", r, re[i]);
         chk("slave error", {31'h0, e}, {31'h0, ra[i] == 12'h024});
      end
      // Count source stays the plain tick pin; subclock never chosen
      run(32'h1);
      wt(6'h20);
      chk("second irq", {26'h0, irq_lines}, 32'h20);
      tk;
      repeat (3) @(negedge clk);
      chk("wrap irqs", {26'h0, irq_lines & 6'h2f}, 32'h26);
      apb(1'b1, 12'h020, 32'h0);
      repeat (2) @(negedge clk);
      chk("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, 12'h020, 32'h3f);
      apb(1'b1, 12'h01c, 32'h3f);
      repeat (2) @(negedge clk);
      chk("cleared irq", {26'h0, irq_lines}, 32'h0);
      run(32'h0);
      apb(1'b1, 12'h000, 32'h3b);
      apb(1'b1, 12'h004, 32'h3b);
      apb(1'b1, 12'h008, 32'ha);
      apb(1'b1, 12'h014, 32'h8);
      run(32'h1);
      wt(6'h3f);
      chk("hour only", {25'h0, irq, irq_lines}, 32'h48);
      run(32'h0);
      apb(1'b1, 12'h01c, 32'h3f);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h3);
      apb(1'b1, 12'h014, 32'h1);
      run(32'h5);
      wt(6'h3f);
      chk("compare irq", {26'h0, irq_lines}, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk("compare count", r, 32'h3);
      apb(1'b1, 12'h000, 32'h11);
      apb(1'b0, 12'h000, 32'h0);
      chk("write while running", r, 32'h3);
      wrap_up;
   end
endmodule : calendar_timer_irq_and_control_bench
`default_nettype wire

// ===== verification/crt_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module crt_core_checker
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [5:0]  irq_lines,
   input wire logic        irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   setup_answer_a: assert property (setup_s |=> pready)
      else $error("no ready one cycle after setup");
   access_only_a: assert property (pready |-> access_s)
      else $error("ready outside an access phase");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   idle_quiet_a: assert property (!psel |=> !pready)
      else $error("ready without a request");
   err_unmapped_a: assert property (pready && paddr > 12'h020 |-> pslverr)
      else $error("no error on unmapped address");
   err_mapped_a: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped address");
   err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   irq_merge_a: assert property (irq == (|irq_lines))
      else $error("irq not the merge of the lines");
endmodule : crt_core_checker
bind crt_core crt_core_checker u_crt_core_checker (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_lines(irq_lines), .irq(irq));
`default_nettype wire
